// file: logic/usb_event_pkg.sv
// Package with the register map, field positions and reset values of the USB event block.
package usb_event_pkg;
    // Register word indices; byte address is index times four.
    localparam logic [5:0] IDX_FLAGS     = 6'h00;
    localparam logic [5:0] IDX_ENABLES   = 6'h01;
    localparam logic [5:0] IDX_SYS_STAT  = 6'h02;
    localparam logic [5:0] IDX_SYS_MASK  = 6'h03;
    // Bit positions of the event flags and enables.
    localparam int BIT_SETUP_OVERWRITE = 0;
    localparam int BIT_RESERVED        = 1;
    localparam int BIT_SETUP_RECEIVED  = 2;
    localparam int BIT_PORT_POWER_ON   = 3;
    localparam int BIT_PORT_POWER_OFF  = 4;
    localparam int BIT_RESUME_REQUEST  = 5;
    localparam int BIT_SUSPEND_REQUEST = 6;
    localparam int BIT_HOST_RESET_REQ  = 7;
    // Bit positions of the bus-side system status.
    localparam int SYS_BIT_UNMAPPED    = 0;
    localparam int SYS_BIT_EP0_NAKED   = 1;
    // Widths, implemented-bit masks and reset values.
    localparam int FLAG_W              = 8;
    localparam int SYS_W               = 2;
    localparam logic [7:0] FLAG_IMPL   = 8'hFD;
    localparam logic [7:0] FUNC_RST_CLR = 8'h7F;
    localparam logic [7:0] FLAG_RESET  = 8'h00;
    localparam logic [7:0] EN_RESET    = 8'h00;
    localparam logic [1:0] SYS_RESET   = 2'h0;
    // AHB constants.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY    = 2'h0;

    // Word index from a byte address.
    function automatic logic [5:0] word_index(input logic [31:0] addr);
        word_index = addr[7:2];
    endfunction : word_index
endpackage : usb_event_pkg

// file: logic/sticky_flags.sv
// Sticky flag bank: hardware sets, a clear vector clears, a set in the same cycle wins.
`timescale 1ns/1ps
module sticky_flags
    import usb_event_pkg::*;
#(
    parameter int             W    = 8,
    parameter logic [W-1:0]   IMPL = '1
)(
    // Clock and reset.
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    // Flag control.
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    // Flag state.
    output logic      [W-1:0] q_o,
    output logic      [W-1:0] next_o
);
    // Set wins over clear so an event landing on a clear is never lost.
    always_comb
    begin
        next_o = ((q_o & ~clr_i) | set_i) & IMPL;
    end

    // Flag storage with synchronous reset.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            q_o <= '0;
        else
            q_o <= next_o;
    end
endmodule : sticky_flags

// file: logic/ahb_lite_regs_slave.sv
// AHB-Lite slave front end: zero-wait writes, one-wait reads with registered read data.
`timescale 1ns/1ps
module ahb_lite_regs_slave
    import usb_event_pkg::*;
(
    // Clock and reset.
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    // AHB-Lite bus.
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic [1:0]       hresp_o,
    output logic [31:0]      hrdata_o,
    // Register side.
    output logic [5:0]       index_o,
    output logic             wr_strobe_o,
    output logic             rd_strobe_o,
    output logic             access_o,
    input  wire logic [31:0] rdata_i
);
    logic wr_pend;
    logic rd_pend;
    logic take;

    // A transfer is taken when selected, NONSEQ or SEQ (htrans bit 1 set, so not idle or busy) and the bus is ready.
    assign take        = hsel_i && htrans_i[1] && hready_i;
    assign access_o    = take;
    assign wr_strobe_o = wr_pend;
    assign rd_strobe_o = rd_pend && !hreadyout_o;

    // Address phase capture; reads stall one cycle so a preceding write is visible.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            wr_pend     <= 1'b0;
            rd_pend     <= 1'b0;
            index_o     <= 6'h00;
            hreadyout_o <= 1'b1;
            hresp_o     <= HRESP_OKAY;
        end
        else if (rd_strobe_o)
        begin
            rd_pend     <= 1'b0;
            hreadyout_o <= 1'b1;
        end
        else
        begin
            wr_pend     <= take && hwrite_i;
            rd_pend     <= take && !hwrite_i;
            hreadyout_o <= !(take && !hwrite_i);
            if (take)
                index_o <= word_index(haddr_i);
        end
    end

    // Read data is loaded at the end of the wait cycle.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            hrdata_o <= 32'h0000_0000;
        else if (rd_strobe_o)
            hrdata_o <= rdata_i;
    end
endmodule : ahb_lite_regs_slave

// file: logic/usb_event_status_mask.sv
// USB event status flags, enable mask and microcontroller interrupt.
// Contract
// - Hardware sets flags; writing one clears, zero keeps.
// - Set flag interrupts only when its enable set.
// - Setup while buffer full sets bit 0.
// - Setup sets bit 2; endpoint 0 NAKed.
// - Port power-on indication sets bit 3.
// - Port power-off indication sets bit 4.
// - Detected resume sets bit 5.
// - Global or selective suspend sets bit 6.
// - Host port reset start sets bit 7.
// - Function reset keeps the reset-request flag.
// - Enables per flag, reset to zero blocking.
`timescale 1ns/1ps
module usb_event_status_mask
    import usb_event_pkg::*;
(
    // Clock and reset.
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    // USB function reset, a level from the reset interconnect.
    input  wire logic        usb_func_reset_i,
    // Event pulses from the serial interface engine.
    input  wire logic        setup_rx_i,
    input  wire logic        setup_buf_full_i,
    input  wire logic        port_power_on_i,
    input  wire logic        port_power_off_i,
    input  wire logic        resume_request_i,
    input  wire logic        global_suspend_i,
    input  wire logic        selective_suspend_i,
    input  wire logic        host_reset_request_i,
    input  wire logic        ep0_token_i,
    // Endpoint 0 override and interrupt.
    output logic             ep0_force_nak_o,
    output logic             irq_o,
    // AHB-Lite bus.
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic [1:0]       hresp_o,
    output logic [31:0]      hrdata_o
);
    logic [5:0]        index;
    logic              wr_strobe;
    logic              rd_strobe;
    logic              access;
    logic [31:0]       rdata;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] next_flags;
    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_clr;
    logic [FLAG_W-1:0] enables;
    logic [SYS_W-1:0]  sys_status;
    logic [SYS_W-1:0]  sys_set;
    logic [SYS_W-1:0]  sys_clr;
    logic [SYS_W-1:0]  sys_mask;
    logic              unmapped;

    // Bus front end; transfer size is always a whole word here.
    ahb_lite_regs_slave u_bus (
        .ref_clk_i   (ref_clk_i),
        .rst_b_i     (rst_b_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hready_i    (hready_i),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .hrdata_o    (hrdata_o),
        .index_o     (index),
        .wr_strobe_o (wr_strobe),
        .rd_strobe_o (rd_strobe),
        .access_o    (access),
        .rdata_i     (rdata)
    );

    // Event set vector; bit 1 never sets.
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[BIT_SETUP_OVERWRITE] = setup_rx_i && setup_buf_full_i;
        flag_set[BIT_SETUP_RECEIVED]  = setup_rx_i;
        flag_set[BIT_PORT_POWER_ON]   = port_power_on_i;
        flag_set[BIT_PORT_POWER_OFF]  = port_power_off_i;
        flag_set[BIT_RESUME_REQUEST]  = resume_request_i;
        flag_set[BIT_SUSPEND_REQUEST] = global_suspend_i || selective_suspend_i;
        flag_set[BIT_HOST_RESET_REQ]  = host_reset_request_i;
    end

    // Clear vector: write-one-to-clear plus the function reset.
    always_comb
    begin
        flag_clr = 8'h00;
        if (wr_strobe && index == IDX_FLAGS)
            flag_clr = hwdata_i[7:0];
        if (usb_func_reset_i)
            flag_clr = flag_clr | FUNC_RST_CLR;
    end

    sticky_flags #(
        .W    (FLAG_W),
        .IMPL (FLAG_IMPL)
    ) u_flags (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .set_i     (flag_set),
        .clr_i     (flag_clr),
        .q_o       (flags),
        .next_o    (next_flags)
    );

    // Enable register; function reset clears it, unlike the system mask and system status registers.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i || usb_func_reset_i)
            enables <= EN_RESET;
        else if (wr_strobe && index == IDX_ENABLES)
            enables <= hwdata_i[7:0] & FLAG_IMPL;
    end

    // Bus-side events: unmapped access and a forced endpoint 0 NAK.
    assign unmapped = access && (word_index(haddr_i) > IDX_SYS_MASK);
    always_comb
    begin
        sys_set = SYS_RESET;
        sys_set[SYS_BIT_UNMAPPED]  = unmapped;
        sys_set[SYS_BIT_EP0_NAKED] = ep0_token_i && flags[BIT_SETUP_RECEIVED];
        sys_clr = (rd_strobe && index == IDX_SYS_STAT) ? 2'h3 : 2'h0;
    end

    // System status clears on read; an event in the read cycle is kept.
    sticky_flags #(
        .W    (SYS_W),
        .IMPL (2'h3)
    ) u_sys (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .set_i     (sys_set),
        .clr_i     (sys_clr),
        .q_o       (sys_status),
        .next_o    ()
    );

    // System mask register.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            sys_mask <= SYS_RESET;
        else if (wr_strobe && index == IDX_SYS_MASK)
            sys_mask <= hwdata_i[1:0];
    end

    // Read mux; unmapped words read as zero.
    always_comb
    begin
        unique case (index)
            IDX_FLAGS:    rdata = {24'h000000, flags};
            IDX_ENABLES:  rdata = {24'h000000, enables};
            IDX_SYS_STAT: rdata = {30'h0, sys_status};
            IDX_SYS_MASK: rdata = {30'h0, sys_mask};
            default:      rdata = 32'h0000_0000;
        endcase
    end

    // Outputs come from flops; the NAK override follows the next flag value to avoid a lag.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            ep0_force_nak_o <= 1'b0;
            irq_o           <= 1'b0;
        end
        else
        begin
            ep0_force_nak_o <= next_flags[BIT_SETUP_RECEIVED];
            irq_o <= |(flags & enables) || |(sys_status & sys_mask);
        end
    end

    // Checks on the flag and interrupt behaviour.
    sequence s_clean_write;
        wr_strobe && index == IDX_FLAGS && flag_set == 8'h00 && !usb_func_reset_i;
    endsequence

    sequence s_setup_busy;
        setup_rx_i && setup_buf_full_i;
    endsequence

    property p_w1c_clears;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_clean_write |=> (flags & $past(hwdata_i[7:0])) == 8'h00;
    endproperty
    a_w1c_clears: assert property (p_w1c_clears) else $error("Written one did not clear flag.");

    property p_w0_keeps;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_clean_write ##0 hwdata_i[7:0] == 8'h00 |=> flags == $past(flags);
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("Writing zeros changed flags.");

    property p_irq_raise;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (flags & enables) != 8'h00 |=> irq_o;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("Enabled flag gave no interrupt.");

    property p_irq_quiet;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (flags & enables) == 8'h00 && (sys_status & sys_mask) == 2'h0 |=> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("Interrupt without enabled flag.");

    property p_overwrite;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_setup_busy |=> flags[BIT_SETUP_OVERWRITE] && flags[BIT_SETUP_RECEIVED] ##0 ep0_force_nak_o;
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("Setup overwrite not flagged.");

    property p_setup_nak;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        ep0_force_nak_o == flags[BIT_SETUP_RECEIVED];
    endproperty
    a_setup_nak: assert property (p_setup_nak) else $error("Endpoint 0 NAK not tied to setup flag.");

    property p_power_on;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        port_power_on_i |=> flags[BIT_PORT_POWER_ON];
    endproperty
    a_power_on: assert property (p_power_on) else $error("Power-on event lost.");

    property p_power_off;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        port_power_off_i |=> flags[BIT_PORT_POWER_OFF];
    endproperty
    a_power_off: assert property (p_power_off) else $error("Power-off event lost.");

    property p_resume;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        resume_request_i |=> flags[BIT_RESUME_REQUEST];
    endproperty
    a_resume: assert property (p_resume) else $error("Resume event lost.");

    property p_suspend;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (global_suspend_i || selective_suspend_i) |=> flags[BIT_SUSPEND_REQUEST];
    endproperty
    a_suspend: assert property (p_suspend) else $error("Suspend event lost.");

    property p_host_reset;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        host_reset_request_i |=> flags[BIT_HOST_RESET_REQ];
    endproperty
    a_host_reset: assert property (p_host_reset) else $error("Host reset event lost.");

    property p_reset_kept;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        usb_func_reset_i && !(wr_strobe && index == IDX_FLAGS) |=>
            flags[BIT_HOST_RESET_REQ] == $past(flags[BIT_HOST_RESET_REQ]) || $past(host_reset_request_i);
    endproperty
    a_reset_kept: assert property (p_reset_kept) else $error("Function reset touched reset flag.");

    property p_en_reset;
        @(posedge ref_clk_i)
        !rst_b_i |=> enables == 8'h00 [*2];
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("Enables not zero after reset.");

    property p_enable_write;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_strobe && index == IDX_ENABLES && !usb_func_reset_i |=> enables == ($past(hwdata_i[7:0]) & FLAG_IMPL);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("Enable write not stored.");

    property p_func_reset_clears;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        usb_func_reset_i && flag_set == 8'h00 |=> (flags & FUNC_RST_CLR) == 8'h00 && enables == EN_RESET;
    endproperty
    a_func_reset_clears: assert property (p_func_reset_clears) else $error("Function reset left flags set.");

    property p_reserved;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !flags[BIT_RESERVED] && !enables[BIT_RESERVED];
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bit became one.");
endmodule : usb_event_status_mask

// file: bench/usb_sie_model.sv
// Behavioural model of the serial interface engine that raises USB event pulses.
`timescale 1ns/1ps
module usb_sie_model (
    // Clock.
    input  wire logic       ref_clk_i,
    // Event lines: 0 setup over full buffer, 1 endpoint 0 token, 2 setup, 3 power on,
    // 4 power off, 5 resume, 6 global suspend, 7 host port reset, 8 selective suspend.
    output logic      [8:0] event_o
);
    // All lines rest low so no stray event is seen before the first pulse.
    initial
    begin
        event_o = '0;
    end

    // One event is one high cycle; the engine always leaves a low cycle between pulses.
    task automatic pulse(input int idx);
        @(posedge ref_clk_i);
        event_o[idx] <= 1'b1;
        @(posedge ref_clk_i);
        event_o <= '0;
    endtask : pulse
endmodule : usb_sie_model

// file: bench/usb_event_status_mask_bench.sv
// Self-checking testbench of the USB event flags, enables and interrupt.
`timescale 1ns/1ps
`define CHK(nm, ex, got) check_count++; if ((got) !== (ex)) begin fail_count++; $display("Error %s expected %h seen %h", nm, ex, got); end
module usb_event_status_mask_bench;
    import usb_event_pkg::*;

    typedef struct {string name; logic [31:0] expect_val;} note_s;

    logic        ref_clk    = 1'b0;
    logic        rst_b      = 1'b0;
    logic        func_reset = 1'b0;
    logic        hsel       = 1'b0;
    logic [31:0] haddr      = 32'h0;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'b0;
    logic [31:0] hwdata     = 32'h0;
    logic        rd_pend    = 1'b0;
    logic [15:0] seed       = 16'h004D;
    logic [7:0]  en;
    logic [8:0]  ev;
    wire         hready;
    wire  [1:0]  hresp;
    wire  [31:0] hrdata;
    wire         nak;
    wire         irq;
    int          fail_count  = 0;
    int          check_count = 0;
    note_s       notes[$];
    note_s       note;
    // Expected flags per event line; an overwrite also marks a setup as received.
    logic [7:0]  exp_tab [9] = '{8'h05, 8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h40};

    // Free-running 50 MHz clock.
    always #10 ref_clk = ~ref_clk;

    usb_sie_model sie (
        .ref_clk_i (ref_clk),
        .event_o   (ev)
    );

    usb_event_status_mask DUT (
        .ref_clk_i            (ref_clk),
        .rst_b_i              (rst_b),
        .usb_func_reset_i     (func_reset),
        .setup_rx_i           (ev[0] | ev[2]),
        .setup_buf_full_i     (ev[0]),
        .port_power_on_i      (ev[3]),
        .port_power_off_i     (ev[4]),
        .resume_request_i     (ev[5]),
        .global_suspend_i     (ev[6]),
        .selective_suspend_i  (ev[8]),
        .host_reset_request_i (ev[7]),
        .ep0_token_i          (ev[1]),
        .ep0_force_nak_o      (nak),
        .irq_o                (irq),
        .hsel_i               (hsel),
        .haddr_i              (haddr),
        .htrans_i             (htrans),
        .hwrite_i             (hwrite),
        .hsize_i              (3'h2),
        .hwdata_i             (hwdata),
        .hready_i             (hready),
        .hreadyout_o          (hready),
        .hresp_o              (hresp),
        .hrdata_o             (hrdata)
    );

    // Pseudo-random source for written values.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // Closing report; every end of the run passes through here.
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // Waits for hready high at a rising edge; a stuck slave ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                fail_count++;
                print_verdict();
            end
            @(posedge ref_clk);
        end
    endtask : wait_ready

    // One single AHB-Lite word transfer; for a read, d is the expected data.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input string nm);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        if (!wr)
        begin
            notes.push_back('{nm, d});
            rd_pend <= 1'b1;
        end
        wait_ready();
        rd_pend <= 1'b0;
    endtask : bus

    // Read monitor: the oldest note is matched against data at the completing edge.
    always @(posedge ref_clk)
    begin
        if (rd_pend === 1'b1 && hready === 1'b1)
        begin
            note = notes.pop_front();
            `CHK(note.name, note.expect_val, hrdata)
            `CHK("hresp", HRESP_OKAY, hresp)
        end
    end

    // Main sequence: reset values, every event, endpoint 0 status, function reset.
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        bus(1'b0, 32'h0, 32'h0, "flags_reset");
        bus(1'b0, 32'h4, 32'h0, "enables_reset");
        bus(1'b1, 32'h4, 32'hFF, "");
        bus(1'b0, 32'h4, 32'hFD, "enables_written");
        for (int i = 0; i < 9; i++)
        begin
            seed = lfsr(seed);
            en = seed[7:0] & FLAG_IMPL;
            bus(1'b1, 32'h4, {24'h0, seed[7:0]}, "");
            sie.pulse(i);
            repeat (2) @(posedge ref_clk);
            `CHK("ep0_nak", exp_tab[i][2], nak)
            `CHK("irq_set", |(exp_tab[i] & en), irq)
            // setup service bracket
            // The in-progress bit is firmware's and lives outside this block.
            bus(1'b1, 32'h0, 32'h0, "");
            // Zeros over the set flags, random ones elsewhere.
            bus(1'b1, 32'h0, {24'h0, seed[15:8] & ~exp_tab[i]}, "");
            bus(1'b0, 32'h0, {24'h0, exp_tab[i]}, "flags_event");
            bus(1'b1, 32'h0, 32'hFF, "");
            bus(1'b0, 32'h0, 32'h0, "flags_cleared");
            `CHK("irq_clear", 1'b0, irq)
        end
        // System events reach the interrupt through their own mask, flag enables off.
        bus(1'b1, 32'h4, 32'h0, "");
        bus(1'b1, 32'hC, 32'h3, "");
        bus(1'b0, 32'hC, 32'h3, "sys_mask_rw");
        sie.pulse(2);
        sie.pulse(1);
        bus(1'b0, 32'h8, 32'h2, "sys_ep0_token");
        `CHK("irq_sys", 1'b1, irq)
        bus(1'b0, 32'h40, 32'h0, "unmapped");
        bus(1'b0, 32'h8, 32'h1, "sys_unmapped");
        @(posedge ref_clk);
        `CHK("irq_sys_clear", 1'b0, irq)
        sie.pulse(7);
        sie.pulse(3);
        func_reset <= 1'b1;
        @(posedge ref_clk);
        func_reset <= 1'b0;
        bus(1'b0, 32'h0, 32'h80, "flags_func_reset");
        bus(1'b0, 32'h4, 32'h0, "enables_func_reset");
        repeat (2) @(posedge ref_clk);
        print_verdict();
    end
endmodule : usb_event_status_mask_bench
